// [dah_pkg.sv]
// shared constants and types of the diskette adapter host port
package dah_pkg;
    localparam int CLK_MHZ = 250;
    localparam logic [9:0] ADDR_DRIVE_CONTROL = 10'h3f2;
    localparam logic [9:0] ADDR_MAIN_STATUS = 10'h3f4;
    localparam logic [9:0] ADDR_DATA_PORT = 10'h3f5;
    localparam logic [7:0] DRIVE_CONTROL_RESET = 8'h00;
    localparam int DC_SEL_LSB = 0;
    localparam int DC_RESET_N = 2;
    localparam int DC_INT_DMA_EN = 3;
    localparam int DC_MOTOR_LSB = 4;
    localparam int MS_REQ_MASTER = 7;
    localparam int MS_DIR_READ = 6;
    localparam int MS_BUSY = 4;
    localparam logic [7:0] INVALID_RESULT = 8'h80;
    localparam logic [4:0] CMD_SENSE_DRIVE = 5'h04;
    localparam logic [31:0] VALID_CMD_MASK = 32'h220236fc;
    localparam logic [6:0] RECAL_STEP_LIMIT = 7'h4d;
    localparam logic [7:0] BAD_CYLINDER = 8'hff;
    localparam int OVERRUN_NS = 12000;
    localparam int OVERRUN_CYCLES = OVERRUN_NS * CLK_MHZ / 1000;
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int PIN_COUNT = 11;
    // aen, iowN, iorN, dack2N, tc, chanReset, fault, wp, ready, trk0, twoSided
    localparam logic [PIN_COUNT-1:0] PIN_IDLE = 11'h38e;
    typedef enum logic [1:0] {
        TC_NORMAL = 2'b00,
        TC_FAILED = 2'b01,
        TC_INVALID = 2'b10,
        TC_READY_LOST = 2'b11
    } dah_term_t;
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_CMD = 2'b01,
        PH_RESULT = 2'b11,
        PH_SPARE = 2'b10
    } dah_phase_t;
endpackage

// [dah_stream_if.sv]
// byte stream carrier between adapter and its fifo
`timescale 1ns/100ps
interface dah_stream_if;
    logic [7:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

// [dah_fifo.sv]
// parameterised byte fifo with valid/ready on both sides
`timescale 1ns/100ps
module dah_fifo
    import dah_pkg::*;
#(
    parameter int WIDTH = FIFO_WIDTH,
    parameter int DEPTH = FIFO_DEPTH
)
(
    input wire logic clk,
    input wire logic rstn,
    dah_stream_if.snk inS,
    dah_stream_if.src outS
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr_reg;
    logic [AW:0] rdPtr_reg;
    logic full;
    logic empty;
    logic push;
    logic pop;

    assign full = (wrPtr_reg[AW] != rdPtr_reg[AW]) && (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]);
    assign empty = (wrPtr_reg == rdPtr_reg);
    assign push = inS.valid && !full;
    assign pop = outS.ready && !empty;
    assign inS.ready = !full;
    assign outS.valid = !empty;
    assign outS.data = mem[rdPtr_reg[AW-1:0]];

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wrPtr_reg[AW-1:0]] <= inS.data;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
        end
        else
        begin
            if (push)
            begin
                wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            if (pop)
            begin
                rdPtr_reg <= rdPtr_reg + 1'b1;
            end
        end
    end
endmodule // dah_fifo

// [dah_adapter.sv]
// diskette adapter: i/o channel port, drive control, result status, dma
`timescale 1ns/100ps
// Behaviour
// - unknown command: no-op, single result 80
// - status0 bits 7:6 give termination code
// - status0 bit 5 on seek end
// - equipment check: fault or 77 steps
// - not ready: drive unready or absent side
// - status0 head bit and unit number
// - status1 bit 7 past last sector
// - unused status bits always zero
// - crc error sets status1 bit5, data status2
// - overrun when host misses byte deadline
// - status1 bit 2 sector not found
// - write protect during write sets bit1
// - missing id mark sets both bit0
// - deleted mark bit6, missing data mark bit0
// - wrong cylinder bit4, ff also bit1
// - scan equal hit bit3, unsatisfied bit2
// - status3 mirrors drive input lines in bits 7:3, head and unit in 2:0
// - drive control bits: select, reset, enable, motors
// - channel reset clears drive control
// - address ignored while address enable active
// - latch write at strobe end; drive read
// - dma acknowledge: drop request, data port, tc
// - dma request raised, dropped by ack/read
// - interrupt on completion, cleared by result read
// - terminal count with ack marks last byte
module dah_adapter
    import dah_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [9:0] ioAddr,
    input wire logic [7:0] ioDataIn,
    output logic [7:0] ioDataOut,
    output logic ioDataOeN,
    input wire logic addrEnable,
    input wire logic ioWriteN,
    input wire logic ioReadN,
    input wire logic dmaAck2N,
    input wire logic termCount,
    input wire logic chanReset,
    output logic dmaReq2,
    output logic intReq6,
    output logic [1:0] driveSelect,
    output logic ctrlResetN,
    output logic intDmaEnable,
    output logic [3:0] motorEnable,
    input wire logic driveFault,
    input wire logic writeProtect,
    input wire logic driveReady,
    input wire logic trackZero,
    input wire logic twoSided,
    output logic [7:0] cmdByte,
    output logic cmdValid,
    input wire logic cmdReady,
    input wire logic engDone,
    input wire logic engReadyChanged,
    input wire logic engSeekEnd,
    input wire logic engRwCmd,
    input wire logic engWriteCmd,
    input wire logic engHead,
    input wire logic [1:0] engUnit,
    input wire logic engRecal,
    input wire logic engStep,
    input wire logic engEndCyl,
    input wire logic engIdCrcErr,
    input wire logic engDataCrcErr,
    input wire logic engNoData,
    input wire logic engIdMarkMiss,
    input wire logic engDeletedMark,
    input wire logic engDataMarkMiss,
    input wire logic engCylValid,
    input wire logic [7:0] engReqCyl,
    input wire logic [7:0] engMediumCyl,
    input wire logic engScanEqual,
    input wire logic engScanUnsat,
    input wire logic engXferReq,
    input wire logic [7:0] engReadByte,
    output logic engXferAck,
    output logic engLastXfer
);
    logic [PIN_COUNT-1:0] pinRaw;
    logic [PIN_COUNT-1:0] pinS1_reg;
    logic [PIN_COUNT-1:0] pinS2_reg;
    logic [PIN_COUNT-1:0] pinS3_reg;
    logic [PIN_COUNT-1:0] pin_reg;
    logic [PIN_COUNT-1:0] pinPrev_reg;
    logic aenS, iowActive, iorActive, dackActive, tcS, chanRstS;
    logic faultS, wpS, readyS, trk0S, twoSideS;
    logic iowEnd, iorEnd;
    logic [9:0] addrLat_reg;
    logic [7:0] dataLat_reg;
    logic selDc, selMs, selData;
    logic [7:0] driveCtl_reg;
    dah_phase_t phase_reg;
    logic [7:0] res_reg [4];
    logic [2:0] resCount_reg;
    logic [2:0] resIdx_reg;
    logic [7:0] st1Acc_reg;
    logic [7:0] st2Acc_reg;
    logic [7:0] st1Now, st2Now, st0, st3;
    logic ecAcc_reg;
    logic nrAcc_reg;
    logic [6:0] stepCount_reg;
    logic recalFail;
    logic [11:0] overrunCnt_reg;
    logic overrunHit;
    logic cylMismatch;
    logic dah_cmdValidCode;
    logic [4:0] cmdCode_reg;
    logic dataWrite, dataRead;
    logic [7:0] readValue;
    logic [7:0] mainStatus;
    logic fifoFull;

    dah_stream_if toFifo ();
    dah_stream_if fromFifo ();

    // pins from outside the clock domain: 3 flops, accepted when 2nd and 3rd agree
    assign pinRaw = {addrEnable, ioWriteN, ioReadN, dmaAck2N, termCount, chanReset,
                     driveFault, writeProtect, driveReady, trackZero, twoSided};
    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++)
        begin : gSync
            always_ff @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    pinS1_reg[gi] <= PIN_IDLE[gi];
                    pinS2_reg[gi] <= PIN_IDLE[gi];
                    pinS3_reg[gi] <= PIN_IDLE[gi];
                    pin_reg[gi] <= PIN_IDLE[gi];
                    pinPrev_reg[gi] <= PIN_IDLE[gi];
                end
                else
                begin
                    pinS1_reg[gi] <= pinRaw[gi];
                    pinS2_reg[gi] <= pinS1_reg[gi];
                    pinS3_reg[gi] <= pinS2_reg[gi];
                    if (pinS2_reg[gi] == pinS3_reg[gi])
                    begin
                        pin_reg[gi] <= pinS3_reg[gi];
                    end
                    pinPrev_reg[gi] <= pin_reg[gi];
                end
            end
        end
    endgenerate

    assign aenS = pin_reg[10];
    assign iowActive = !pin_reg[9];
    assign iorActive = !pin_reg[8];
    assign dackActive = !pin_reg[7];
    assign tcS = pin_reg[6];
    assign chanRstS = pin_reg[5];
    assign faultS = pin_reg[4];
    assign wpS = pin_reg[3];
    assign readyS = pin_reg[2];
    assign trk0S = pin_reg[1];
    assign twoSideS = pin_reg[0];
    assign iowEnd = !pinPrev_reg[9] && pin_reg[9];
    assign iorEnd = !pinPrev_reg[8] && pin_reg[8];

    // address and data are stable for the whole strobe; keep the last strobed sample
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            addrLat_reg <= '0;
            dataLat_reg <= '0;
        end
        else if (iowActive || iorActive)
        begin
            addrLat_reg <= ioAddr;
            dataLat_reg <= ioDataIn;
        end
    end

    assign selDc = !aenS && !dackActive && addrLat_reg == ADDR_DRIVE_CONTROL;
    assign selMs = !aenS && !dackActive && addrLat_reg == ADDR_MAIN_STATUS;
    assign selData = dackActive || (!aenS && addrLat_reg == ADDR_DATA_PORT);
    assign dataWrite = iowEnd && selData;
    assign dataRead = iorEnd && selData;

    // drive control register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            driveCtl_reg <= DRIVE_CONTROL_RESET;
        else if (chanRstS)
            driveCtl_reg <= DRIVE_CONTROL_RESET;
        else if (iowEnd && selDc)
            driveCtl_reg <= dataLat_reg;
    end

    assign driveSelect = driveCtl_reg[DC_SEL_LSB +: 2];
    assign ctrlResetN = driveCtl_reg[DC_RESET_N];
    assign intDmaEnable = driveCtl_reg[DC_INT_DMA_EN];
    assign motorEnable = driveCtl_reg[DC_MOTOR_LSB +: 4];

    // command bytes go to the engine through the fifo
    assign dah_cmdValidCode = VALID_CMD_MASK[dataLat_reg[4:0]];
    assign toFifo.data = dataLat_reg;
    assign toFifo.valid = dataWrite && !(phase_reg == PH_IDLE && !dah_cmdValidCode && !dackActive);
    assign fifoFull = !toFifo.ready;
    assign cmdByte = fromFifo.data;
    assign cmdValid = fromFifo.valid;
    assign fromFifo.ready = cmdReady;

    dah_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) uFifo (
        .clk(clk),
        .rstn(rstn),
        .inS(toFifo),
        .outS(fromFifo)
    );

    // live status terms
    assign cylMismatch = engCylValid && engReqCyl != engMediumCyl;
    assign st1Now = {engEndCyl, 1'b0, engIdCrcErr | engDataCrcErr, 1'b0,
                     1'b0, engNoData, engWriteCmd & wpS, engIdMarkMiss};
    assign st2Now = {1'b0, engDeletedMark, engDataCrcErr, cylMismatch,
                     engScanEqual, engScanUnsat,
                     cylMismatch && engMediumCyl == BAD_CYLINDER,
                     engDataMarkMiss | engIdMarkMiss};
    assign recalFail = engRecal && !trk0S && stepCount_reg >= RECAL_STEP_LIMIT;
    assign overrunHit = overrunCnt_reg == 12'(OVERRUN_CYCLES);

    // sticky error accumulation across one command; a new command clears it
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st1Acc_reg <= '0;
            st2Acc_reg <= '0;
            ecAcc_reg <= 1'b0;
            nrAcc_reg <= 1'b0;
        end
        else if (phase_reg == PH_IDLE && dataWrite)
        begin
            st1Acc_reg <= '0;
            st2Acc_reg <= '0;
            ecAcc_reg <= 1'b0;
            nrAcc_reg <= 1'b0;
        end
        else if (phase_reg == PH_CMD)
        begin
            st1Acc_reg <= st1Acc_reg | st1Now | {3'b000, overrunHit, 4'h0};
            st2Acc_reg <= st2Acc_reg | st2Now;
            ecAcc_reg <= ecAcc_reg | faultS | recalFail;
            nrAcc_reg <= nrAcc_reg | (engRwCmd && (!readyS || (engHead && !twoSideS)));
        end
    end

    // recalibrate step counter
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            stepCount_reg <= '0;
        else if (!engRecal || trk0S)
            stepCount_reg <= '0;
        else if (engStep && stepCount_reg < RECAL_STEP_LIMIT)
            stepCount_reg <= stepCount_reg + 7'h01;
    end

    // host service deadline for a pending byte
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            overrunCnt_reg <= '0;
        else if (!engXferReq || engXferAck)
            overrunCnt_reg <= '0;
        else if (!overrunHit)
            overrunCnt_reg <= overrunCnt_reg + 12'h001;
    end

    assign st0 = {engReadyChanged ? TC_READY_LOST :
                  ((|(st1Acc_reg | st1Now | st2Acc_reg | st2Now)) || ecAcc_reg || nrAcc_reg)
                      ? TC_FAILED : TC_NORMAL,
                  engSeekEnd, ecAcc_reg | faultS | recalFail,
                  nrAcc_reg, engHead, engUnit};
    assign st3 = {faultS, wpS, readyS, trk0S, twoSideS, engHead, engUnit};

    // phase sequencing and result queue
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            phase_reg <= PH_IDLE;
            resCount_reg <= '0;
            resIdx_reg <= '0;
            cmdCode_reg <= '0;
            for (int i = 0; i < 4; i++)
            begin
                res_reg[i] <= '0;
            end
        end
        else if (chanRstS || !ctrlResetN)
        begin
            phase_reg <= PH_IDLE; // reset aborts any command in flight
            resCount_reg <= '0;
            resIdx_reg <= '0;
        end
        else
        begin
            case (phase_reg)
                PH_IDLE:
                begin
                    if (dataWrite && !dackActive)
                    begin
                        cmdCode_reg <= dataLat_reg[4:0];
                        if (!dah_cmdValidCode)
                        begin
                            res_reg[0] <= INVALID_RESULT;
                            resCount_reg <= 3'd1;
                            resIdx_reg <= '0;
                            phase_reg <= PH_RESULT;
                        end
                        else
                        begin
                            phase_reg <= PH_CMD;
                        end
                    end
                end
                PH_CMD:
                begin
                    if (engDone)
                    begin
                        resIdx_reg <= '0;
                        phase_reg <= PH_RESULT;
                        if (cmdCode_reg == CMD_SENSE_DRIVE || (engRwCmd == 1'b0 && engSeekEnd))
                        begin
                            res_reg[0] <= engSeekEnd ? st0 : st3;
                            resCount_reg <= 3'd1;
                        end
                        else
                        begin
                            res_reg[0] <= st0;
                            res_reg[1] <= st1Acc_reg | st1Now | {3'b000, overrunHit, 4'h0};
                            res_reg[2] <= st2Acc_reg | st2Now;
                            res_reg[3] <= st3;
                            resCount_reg <= 3'd4;
                        end
                    end
                end
                PH_RESULT:
                begin
                    if (dataRead && !dackActive)
                    begin
                        resIdx_reg <= resIdx_reg + 3'd1;
                        if (resIdx_reg + 3'd1 >= resCount_reg)
                        begin
                            phase_reg <= PH_IDLE;
                        end
                    end
                end
                default:
                begin
                    phase_reg <= PH_IDLE;
                end
            endcase
        end
    end

    assign mainStatus = {!fifoFull || phase_reg == PH_RESULT, phase_reg == PH_RESULT, 1'b0,
                         phase_reg != PH_IDLE, 4'h0};

    always_comb
    begin
        readValue = 8'h00;
        if (dackActive)
        begin
            readValue = engReadByte;
        end
        else if (selMs)
        begin
            readValue = mainStatus;
        end
        else if (selData && phase_reg == PH_RESULT)
        begin
            readValue = res_reg[resIdx_reg[1:0]];
        end
    end

    // read drive: bus enable held for the whole read strobe, low while driving
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ioDataOut <= 8'h00;
            ioDataOeN <= 1'b1;
        end
        else
        begin
            ioDataOut <= readValue;
            ioDataOeN <= !(iorActive && (selData || selMs));
        end
    end

    // dma request and engine handshake
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dmaReq2 <= 1'b0;
            engXferAck <= 1'b0;
            engLastXfer <= 1'b0;
        end
        else
        begin
            engXferAck <= dackActive && (iorEnd || iowEnd);
            engLastXfer <= dackActive && tcS && (iorEnd || iowEnd);
            if (dackActive || dataRead || !intDmaEnable || chanRstS)
            begin
                dmaReq2 <= 1'b0;
            end
            else if (engXferReq && !fifoFull && !engXferAck)
            begin
                dmaReq2 <= 1'b1;
            end
        end
    end

    // interrupt: completion or terminal count under ack; set beats clear
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            intReq6 <= 1'b0;
        end
        else if (!intDmaEnable || chanRstS)
        begin
            intReq6 <= 1'b0;
        end
        else if ((phase_reg == PH_CMD && engDone) || (phase_reg == PH_IDLE && toFifo.valid == 1'b0
                 && dataWrite) || (dackActive && tcS))
        begin
            intReq6 <= 1'b1;
        end
        else if (dataRead && !dackActive && phase_reg == PH_RESULT)
        begin
            intReq6 <= 1'b0;
        end
    end
endmodule // dah_adapter

// [dah_adapter_props.sv]
// concurrent checks on the adapter port behaviour
`timescale 1ns/100ps
module dah_adapter_props
    import dah_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ioReadN,
    input wire logic ioWriteN,
    input wire logic addrEnable,
    input wire logic dmaAck2N,
    input wire logic chanReset,
    input wire logic ioDataOeN,
    input wire logic dmaReq2,
    input wire logic intDmaEnable,
    input wire logic ctrlResetN,
    input wire logic [1:0] driveSelect,
    input wire logic [3:0] motorEnable,
    input wire logic [7:0] cmdByte,
    input wire logic cmdValid,
    input wire logic cmdReady,
    input wire logic engXferAck,
    input wire logic engLastXfer
);
    logic [7:0] ctl;
    assign ctl = {motorEnable, intDmaEnable, ctrlResetN, driveSelect};
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    property p_ctl_clear; chanReset[*6] |-> ctl == 8'h00; endproperty
    a_ctl_clear: assert property (p_ctl_clear) else $error("control not cleared");
    property p_ctl_hold; (ioWriteN && !chanReset)[*8] |=> $stable(ctl); endproperty
    a_ctl_hold: assert property (p_ctl_hold) else $error("control moved");
    property p_oe_release; ioReadN[*7] |-> ioDataOeN; endproperty
    a_oe_release: assert property (p_oe_release) else $error("bus driven idle");
    property p_aen_ignore; (addrEnable && dmaAck2N)[*8] |-> ioDataOeN; endproperty
    a_aen_ignore: assert property (p_aen_ignore) else $error("decode under aen");
    property p_dack_drop; (!dmaAck2N)[*6] |-> !dmaReq2; endproperty
    a_dack_drop: assert property (p_dack_drop) else $error("request kept");
    property p_req_en; dmaReq2 |-> intDmaEnable; endproperty
    a_req_en: assert property (p_req_en) else $error("request disabled");
    property p_last_ack; engLastXfer |-> engXferAck; endproperty
    a_last_ack: assert property (p_last_ack) else $error("last without ack");
    property p_fifo_hold; cmdValid && !cmdReady |=> cmdValid && $stable(cmdByte); endproperty
    a_fifo_hold: assert property (p_fifo_hold) else $error("byte dropped");
endmodule // dah_adapter_props
bind dah_adapter dah_adapter_props u_props (.clk, .rstn, .ioReadN, .ioWriteN, .addrEnable,
    .dmaAck2N, .chanReset, .ioDataOeN, .dmaReq2, .intDmaEnable, .ctrlResetN, .driveSelect,
    .motorEnable, .cmdByte, .cmdValid, .cmdReady, .engXferAck, .engLastXfer);

// [dah_host_model.sv]
// host cpu and dma controller on the i/o channel
`timescale 1ns/100ps
module dah_host_model
(
    input wire logic clk,
    output logic [9:0] ioAddr,
    output logic [7:0] ioDataIn,
    output logic addrEnable,
    output logic ioWriteN,
    output logic ioReadN,
    output logic dmaAck2N,
    output logic termCount
);
    initial
    begin
        {ioAddr, ioDataIn} = 18'h0;
        {addrEnable, ioWriteN, ioReadN, dmaAck2N, termCount} = 5'b01110;
    end
    task automatic cyc(input logic [9:0] a, input logic [7:0] d, input logic aen,
        input logic wr, input logic dack, input logic tc);
        @(negedge clk);
        ioAddr = a;
        ioDataIn = d;
        addrEnable = aen;
        dmaAck2N = ~dack;
        termCount = tc;
        ioWriteN = ~wr;
        ioReadN = wr;
        repeat (6) @(negedge clk);
        ioWriteN = 1'b1;
        ioReadN = 1'b1;
        // qualifiers outlive the strobe so its synced trailing edge still sees them
        repeat (5) @(negedge clk);
        ioAddr = ~a;
        ioDataIn = ~d;
        {addrEnable, dmaAck2N, termCount} = 3'b010;
        repeat (4) @(negedge clk);
    endtask
endmodule // dah_host_model

// [dah_adapter_tb.sv]
// self-checking bench for the diskette adapter host port
`timescale 1ns/100ps
module dah_adapter_tb
    import dah_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic chanReset = 1'b0;
    logic cmdReady = 1'b1;
    logic driveFault, writeProtect, driveReady, trackZero, twoSided, engDone, engHead;
    logic engReadyChanged, engSeekEnd, engRwCmd, engWriteCmd, engRecal, engStep, engEndCyl;
    logic engIdCrcErr, engDataCrcErr, engNoData, engIdMarkMiss, engDeletedMark;
    logic engDataMarkMiss, engCylValid, engScanEqual, engScanUnsat, engXferReq, lastSeen;
    logic [1:0] engUnit, driveSelect;
    logic [7:0] engReqCyl, engMediumCyl, engReadByte, ioDataIn, ioDataOut, cmdByte, ctl, st3Exp;
    logic [9:0] ioAddr;
    logic addrEnable, ioWriteN, ioReadN, dmaAck2N, termCount, ioDataOeN, dmaReq2, intReq6;
    logic ctrlResetN, intDmaEnable, cmdValid, engXferAck, engLastXfer;
    logic [3:0] motorEnable;
    logic [15:0] expQ[$];
    logic [7:0] cmdQ[$];
    logic [15:0] fl[3] = '{16'h2000, 16'h22fc, 16'ha000};
    logic [1:0] tc[3] = '{2'b00, 2'b01, 2'b11};
    logic [7:0] s1[3] = '{8'h00, 8'ha5, 8'h00};
    logic [7:0] s2[3] = '{8'h00, 8'h73, 8'h00};
    int error_cnt = 0;
    int n_compared = 0;
    int oeCnt = 0;
    assign ctl = {motorEnable, intDmaEnable, ctrlResetN, driveSelect};
    assign st3Exp = {driveFault, writeProtect, driveReady, trackZero, twoSided, engHead, engUnit};
    always #2 clk = ~clk;
    dah_host_model host (.clk, .ioAddr, .ioDataIn, .addrEnable, .ioWriteN, .ioReadN,
        .dmaAck2N, .termCount);
    dah_adapter DUT (.clk, .rstn, .ioAddr, .ioDataIn, .ioDataOut, .ioDataOeN, .addrEnable,
        .ioWriteN, .ioReadN, .dmaAck2N, .termCount, .chanReset, .dmaReq2, .intReq6,
        .driveSelect, .ctrlResetN, .intDmaEnable, .motorEnable, .driveFault, .writeProtect,
        .driveReady, .trackZero, .twoSided, .cmdByte, .cmdValid, .cmdReady, .engDone,
        .engReadyChanged, .engSeekEnd, .engRwCmd, .engWriteCmd, .engHead, .engUnit, .engRecal,
        .engStep, .engEndCyl, .engIdCrcErr, .engDataCrcErr, .engNoData, .engIdMarkMiss,
        .engDeletedMark, .engDataMarkMiss, .engCylValid, .engReqCyl, .engMediumCyl,
        .engScanEqual, .engScanUnsat, .engXferReq, .engReadByte, .engXferAck, .engLastXfer);
    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // a drive with nothing noted is itself a mismatch
    task automatic chk_bus();
        logic [15:0] e;
        if (expQ.size() == 0)
            chk(8'(ioDataOeN), 8'h01);
        else
        begin
            e = expQ.pop_front();
            chk(ioDataOut & e[15:8], e[7:0] & e[15:8]);
        end
    endtask
    task automatic note(input logic [7:0] m, input logic [7:0] d);
        expQ.push_back({m, d});
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic aen);
        host.cyc(a, d, aen, 1'b1, 1'b0, 1'b0);
    endtask
    task automatic rd(input logic [9:0] a);
        host.cyc(a, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
    endtask
    task automatic engdo(input logic [7:0] code, input logic [15:0] f);
        {engReadyChanged, engSeekEnd, engRwCmd, engWriteCmd, engRecal, engStep, engEndCyl,
            engIdCrcErr, engDataCrcErr, engNoData, engIdMarkMiss, engDeletedMark,
            engDataMarkMiss, engCylValid, engScanEqual, engScanUnsat} = f;
        cmdQ.push_back(code);
        wr(ADDR_DATA_PORT, code, 1'b0);
        engDone = 1'b1;
        @(negedge clk);
        engDone = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    always @(negedge clk)
    begin
        oeCnt <= (ioDataOeN === 1'b0) ? oeCnt + 1 : 0;
        cmdReady = 1'($urandom);
        if (cmdValid === 1'b1 && cmdReady === 1'b1)
            chk(cmdByte, cmdQ.pop_front());
        if (engXferAck === 1'b1)
            engXferReq <= 1'b0;
        if (engLastXfer === 1'b1)
            lastSeen <= 1'b1;
        if (oeCnt == 2)
            chk_bus();
    end
    initial
    begin
        #200000;
        error_cnt++;
        close_out();
    end
    initial
    begin
        logic [7:0] v;
        void'($urandom(32'h89722690));
        {driveFault, writeProtect, driveReady, trackZero, twoSided, engHead, engUnit} = 8'h00;
        {engDone, engXferReq, lastSeen, engReqCyl, engMediumCyl, engReadByte} = 27'h0;
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        chk(ctl, DRIVE_CONTROL_RESET);
        for (int i = 0; i < 4; i++)
        begin
            v = {4'($urandom), 2'b11, 2'(i)};
            wr(ADDR_DRIVE_CONTROL, v, 1'b0);
            chk(ctl, v);
        end
        wr(ADDR_DRIVE_CONTROL, 8'h00, 1'b1);
        wr(10'h3f3, 8'h00, 1'b0);
        wr(ADDR_MAIN_STATUS, 8'h00, 1'b0);
        chk(ctl, v);
        host.cyc(ADDR_MAIN_STATUS, 8'h00, 1'b1, 1'b0, 1'b0, 1'b0);
        note(8'hd0, 8'h80);
        rd(ADDR_MAIN_STATUS);
        wr(ADDR_DATA_PORT, 8'h00, 1'b0);
        chk(8'(intReq6), 8'h01);
        note(8'hff, INVALID_RESULT);
        rd(ADDR_DATA_PORT);
        chk(8'(intReq6), 8'h00);
        note(8'hd0, 8'h80);
        rd(ADDR_MAIN_STATUS);
        {driveFault, writeProtect, driveReady, trackZero, twoSided, engHead, engUnit} = 8'($urandom);
        engdo({3'b000, CMD_SENSE_DRIVE}, 16'h0000);
        note(8'hff, st3Exp);
        rd(ADDR_DATA_PORT);
        {driveFault, driveReady, engReqCyl, engMediumCyl} = {2'b01, 8'h05, BAD_CYLINDER};
        engdo(8'h07, 16'h4800);
        note(8'hff, {5'b00100, engHead, engUnit});
        rd(ADDR_DATA_PORT);
        for (int k = 0; k < 3; k++)
        begin
            engdo(8'h06, fl[k]);
            chk(8'(intReq6), 8'h01);
            note(8'hff, {tc[k] | {1'b0, engHead & ~twoSided}, 2'b00,
                         engHead & ~twoSided, engHead, engUnit});
            note(8'hff, s1[k]);
            note(8'hff, s2[k]);
            note(8'hff, st3Exp);
            repeat (4) rd(ADDR_DATA_PORT);
        end
        engReadByte = 8'($urandom);
        engXferReq = 1'b1;
        for (int t = 0; t < 40 && dmaReq2 !== 1'b1; t++) @(negedge clk);
        chk(8'(dmaReq2), 8'h01);
        note(8'hff, engReadByte);
        host.cyc(10'h000, 8'h00, 1'b1, 1'b0, 1'b1, 1'b1);
        chk(8'(dmaReq2), 8'h00);
        chk(8'({lastSeen, intReq6}), 8'h03);
        chanReset = 1'b1;
        repeat (8) @(negedge clk);
        chanReset = 1'b0;
        repeat (4) @(negedge clk);
        chk(ctl, 8'h00);
        chk(8'(expQ.size() + cmdQ.size()), 8'h00);
        close_out();
    end
endmodule // dah_adapter_tb
